// >>> sim/pm_caps_reg_checker.sv
// Purpose: Concurrent checks on the capabilities word and access port.
// Assumes: One clock; request and load checks are gated by ce.
// Notes:   Bound to every instance of the top module.

`timescale 1ns/1ps

module pm_caps_reg_checker (
    // Clock and reset
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        ce,
    // Access port
    input wire logic        cfg_rd,
    input wire logic        cfg_wr,
    input wire logic [7:0]  cfg_addr,
    input wire logic [3:0]  cfg_be,
    input wire logic        cfg_ack,
    input wire logic        cfg_hit,
    input wire logic [31:0] cfg_rdata,
    // Loader and decoded state
    input wire logic        store_valid,
    input wire logic [15:0] store_data,
    input wire logic        wake_from_cold_capable,
    input wire logic [2:0]  standby_supply,
    input wire logic [15:0] caps_word,
    input wire logic        misc_loaded
);
    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    AST_WAKE_MASK: assert property (caps_word[14:11] == 4'hF)
        else $error("wake state mask not all ones");
    AST_DOZE: assert property (caps_word[10:9] == 2'b11)
        else $error("doze support bits not set");
    AST_LOW_ZERO: assert property (
        caps_word[5:3] == 3'b000)
        else $error("bits 5 to 3 not zero");
    AST_SPEC: assert property (caps_word[2:0] == 3'b010)
        else $error("spec level wrong");
    AST_STANDBY: assert property (
        caps_word[8:6] == {2'b00, caps_word[15]})
        else $error("standby code does not follow cold-wake bit");
    // Two enabled edges from strobe to word
    AST_COLD_MIRROR: assert property (
        ce && store_valid ##1 ce |-> ##1
            caps_word[15] == $past(store_data[15], 2))
        else $error("cold-wake bit did not follow loaded word");
    AST_WRITE_IGNORED: assert property (
        ce && cfg_wr && !cfg_rd ##1 ce |-> cfg_ack && cfg_rdata == 32'h0)
        else $error("write not acknowledged with zero data");
    AST_READ_DATA: assert property (
        ce && cfg_rd && cfg_addr[7:2] == 6'h11 && cfg_be == 4'hC ##1 ce
        |-> cfg_ack && cfg_hit && cfg_rdata == {$past(caps_word), 16'h0})
        else $error("read data differs from capabilities word");
    AST_OUT_MIRROR: assert property (
        ce |=> wake_from_cold_capable == $past(caps_word[15])
            && standby_supply == $past(caps_word[8:6]))
        else $error("decoded outputs do not trail the word");

    // Main scenarios reached
    cover property (cfg_ack && cfg_hit && cfg_rdata != 32'h0);
    cover property (ce && cfg_wr ##1 cfg_ack);
    cover property ($rose(wake_from_cold_capable));
    cover property ($rose(misc_loaded));
endmodule : pm_caps_reg_checker

bind pm_caps_reg pm_caps_reg_checker i_pm_caps_reg_checker (
    .clock(clock), .rst_n(rst_n), .ce(ce), .cfg_rd(cfg_rd),
    .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
    .cfg_ack(cfg_ack), .cfg_hit(cfg_hit), .cfg_rdata(cfg_rdata),
    .store_valid(store_valid), .store_data(store_data),
    .wake_from_cold_capable(wake_from_cold_capable),
    .standby_supply(standby_supply), .caps_word(caps_word),
    .misc_loaded(misc_loaded));

// >>> sim/pm_caps_reg_test.sv
// Purpose: Self-checking bench for the capabilities word.
// Assumes: One request in flight at a time; ce dropped in one test.
// Notes:   Expected read and load words are built field by field, not copied.

`timescale 1ns/1ps

`define CHK(what, exp, got) begin \
    n_tests++; \
    if ((got) !== (exp)) begin \
        err_total++; \
        $display("MISMATCH %s expected %h seen %h", what, exp, got); \
    end \
end

module pm_caps_reg_test;
    logic        clock;
    logic        rst_n;
    logic        ce;
    logic        cfg_rd;
    logic        cfg_wr;
    logic [7:0]  cfg_addr;
    logic [3:0]  cfg_be;
    logic [31:0] cfg_wdata;
    logic        cfg_ack;
    logic        cfg_hit;
    logic [31:0] cfg_rdata;
    logic        store_valid;
    logic [15:0] store_data;
    logic        store_done;
    logic        wake_from_cold_capable;
    logic [2:0]  standby_supply;
    logic [15:0] caps_word;
    logic        misc_loaded;
    logic [31:0] rd_data;
    logic        rd_hit;
    int          err_total;
    int          n_tests;

    pm_caps_reg i_pm_caps_reg (
        .clock(clock), .rst_n(rst_n), .ce(ce), .cfg_rd(cfg_rd),
        .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
        .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_hit(cfg_hit),
        .cfg_rdata(cfg_rdata), .store_valid(store_valid),
        .store_data(store_data), .store_done(store_done),
        .wake_from_cold_capable(wake_from_cold_capable),
        .standby_supply(standby_supply), .caps_word(caps_word),
        .misc_loaded(misc_loaded));

    // 40 MHz clock
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Word built from the field values, cold-wake bit as input
    function automatic logic [15:0] exp_caps(input logic cold);
        return {cold, 4'hF, 2'b11, 2'b00, cold, 3'b000, 3'b010};
    endfunction : exp_caps

    // One request; outputs sampled at the falling edge, off the update
    task automatic cfg_access(input logic rd, input logic wr,
                              input logic [7:0] addr,
                              input logic [3:0] be,
                              input logic [31:0] wd);
        @(posedge clock);
        cfg_rd    <= rd;
        cfg_wr    <= wr;
        cfg_addr  <= addr;
        cfg_be    <= be;
        cfg_wdata <= wd;
        @(posedge clock);
        cfg_rd <= 1'b0;
        cfg_wr <= 1'b0;
        @(negedge clock);
        rd_hit  = cfg_hit;
        rd_data = cfg_rdata;
        `CHK("ack", 1'b1, cfg_ack)
    endtask : cfg_access

    task automatic check_read(input logic [7:0] addr,
                              input logic [3:0] be, input logic cold);
        logic [15:0] c;
        logic        h;
        logic [31:0] e;
        c = exp_caps(cold);
        h = (addr[7:2] == 6'h11) && (be[3] || be[2]);
        e = {be[3] ? c[15:8] : 8'h00, be[2] ? c[7:0] : 8'h00, 16'h0000};
        cfg_access(1'b1, 1'b0, addr, be, 32'h0);
        `CHK("hit", h, rd_hit)
        `CHK("rdata", h ? e : 32'h0, rd_data)
    endtask : check_read

    // Loader strobe, then wait past the three-edge answer
    task automatic store(input logic [15:0] d);
        @(posedge clock);
        store_valid <= 1'b1;
        store_data  <= d;
        store_done  <= 1'b1;
        @(posedge clock);
        store_valid <= 1'b0;
        store_done  <= 1'b0;
        repeat (3) @(posedge clock);
        @(negedge clock);
        `CHK("caps", exp_caps(d[15]), caps_word)
        `CHK("cold", d[15], wake_from_cold_capable)
        `CHK("standby", {2'b00, d[15]}, standby_supply)
        `CHK("loaded", 1'b1, misc_loaded)
    endtask : store

    task complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : complete_run

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    // Watchdog well beyond the fewer than 100 cycles the tests need
    initial begin
        repeat (3000) @(posedge clock);
        err_total++;
        $display("watchdog expired");
        complete_run();
    end

    initial begin
        err_total = 0;
        n_tests = 0;
        rst_n = 1'b0;
        ce = 1'b1;
        cfg_rd = 1'b0;
        cfg_wr = 1'b0;
        cfg_addr = 8'h00;
        cfg_be = 4'h0;
        cfg_wdata = 32'h0;
        store_valid = 1'b0;
        store_data = 16'h0000;
        store_done = 1'b0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        @(negedge clock);
        `CHK("caps reset", 16'h7E02, caps_word)
        `CHK("rst low", 8'h02, caps_word[7:0])
        `CHK("standby reset", 3'h0, standby_supply)
        `CHK("loaded reset", 1'b0, misc_loaded)
        $display("test reset values done");
        for (int b = 0; b < 16; b++) begin
            check_read(8'h44, b[3:0], 1'b0);
        end
        check_read(8'h47, 4'hC, 1'b0);
        check_read(8'h48, 4'hF, 1'b0);
        check_read(8'h40, 4'hC, 1'b0);
        $display("test lanes and decode done");
        cfg_access(1'b0, 1'b1, 8'h44, 4'hF, 32'hFFFF_FFFF);
        `CHK("write data", 32'h0, rd_data)
        `CHK("write hit", 1'b1, rd_hit)
        // Read and write together count once and still return the word
        cfg_access(1'b1, 1'b1, 8'h44, 4'hC, 32'hFFFF_FFFF);
        `CHK("rd and wr", {exp_caps(1'b0), 16'h0000}, rd_data)
        cfg_access(1'b0, 1'b1, 8'h44, 4'hF, 32'h0000_0000);
        check_read(8'h44, 4'hC, 1'b0);
        $display("test writes ignored done");
        store(16'h8000);
        check_read(8'h44, 4'hC, 1'b1);
        store(16'h7FFF);
        check_read(8'h44, 4'hC, 1'b0);
        $display("test storage load done");
        // Freeze: a read and a load made while ce is low leave no trace
        store(16'h8000);
        @(posedge clock);
        ce          <= 1'b0;
        store_valid <= 1'b1;
        store_data  <= 16'h0000;
        cfg_rd      <= 1'b1;
        repeat (2) @(posedge clock);
        ce          <= 1'b1;
        store_valid <= 1'b0;
        cfg_rd      <= 1'b0;
        @(negedge clock);
        `CHK("frozen ack", 1'b0, cfg_ack)
        repeat (3) @(posedge clock);
        @(negedge clock);
        `CHK("frozen caps", exp_caps(1'b1), caps_word)
        `CHK("frozen cold", 1'b1, wake_from_cold_capable)
        $display("test clock enable done");
        // Mid-run reset drops the loaded word and the sticky flag
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        @(negedge clock);
        `CHK("caps rerun", 16'h7E02, caps_word)
        `CHK("cold rerun", 1'b0, wake_from_cold_capable)
        `CHK("loaded rerun", 1'b0, misc_loaded)
        check_read(8'h44, 4'hC, 1'b0);
        $display("test mid-run reset done");
        complete_run();
    end
endmodule : pm_caps_reg_test

// >>> src/cfg_reply_mux.sv
// Purpose: Decodes a configuration access and places the word on lanes.
// Assumes: Dword-aligned address; low two address bits are ignored.
// Notes:   Only the upper half of dword 44h belongs to this block.

`timescale 1ns/1ps

module cfg_reply_mux (
    pm_cap_if.reply cap
);

    logic dword_match;

    // Claim only when an upper lane of the owning dword is enabled
    assign dword_match = (cap.addr[7:2] == pm_cap_pkg::CAPS_DWORD[7:2]);
    assign cap.hit     = dword_match && (cap.be[3] || cap.be[2]);

    // Per-lane steering; lanes not enabled or not ours read zero
    always_comb begin
        cap.rdata = pm_cap_pkg::RDATA_RESET;
        if (dword_match) begin
            if (cap.be[2]) begin
                cap.rdata[23:16] = cap.caps_word[7:0];
            end
            if (cap.be[3]) begin
                cap.rdata[31:24] = cap.caps_word[15:8];
            end
        end
    end

endmodule : cfg_reply_mux

// >>> src/misc_shadow.sv
// Purpose: Holds the miscellaneous configuration word from storage.
// Assumes: Storage loader runs on the same clock as this block.
// Notes:   Later loads are accepted, so the cold-wake bit may move.

`timescale 1ns/1ps

module misc_shadow (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        ce,
    // Nonvolatile storage loader
    input  wire logic        store_valid,
    input  wire logic [15:0] store_data,
    input  wire logic        store_done,
    // Shared state
    pm_cap_if.shadow         cap
);

    logic [15:0] misc_reg;
    logic        loaded_reg;

    // Shadow of the word written by the loader
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            misc_reg <= pm_cap_pkg::MISC_RESET;
        end else if (ce && store_valid) begin
            misc_reg <= store_data;
        end
    end

    // Sticky flag: load has completed at least once
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            loaded_reg <= 1'b0;
        end else if (ce && store_done) begin
            loaded_reg <= 1'b1;
        end
    end

    assign cap.cold_wake   = misc_reg[pm_cap_pkg::MISC_COLD_BIT];
    assign cap.misc_loaded = loaded_reg;

endmodule : misc_shadow

// >>> src/pm_cap_if.sv
// Purpose: Carries cold-wake state and request decode between blocks.
// Assumes: All signals on the configuration clock.
// Notes:   Three modports: storage shadow, assembler, reply mux.

`timescale 1ns/1ps

interface pm_cap_if;
    logic        cold_wake;     // Mirrored miscellaneous bit
    logic        misc_loaded;   // Storage load has completed
    logic [15:0] caps_word;     // Assembled capabilities word
    logic [7:0]  addr;          // Request byte address
    logic [3:0]  be;            // Request byte enables
    logic        hit;           // Request claims this word
    logic [31:0] rdata;         // Read data for the claimed lanes

    modport shadow    (output cold_wake, output misc_loaded);
    modport assembler (input cold_wake, input misc_loaded,
                       input hit, input rdata,
                       output caps_word, output addr, output be);
    modport reply     (input caps_word, input addr, input be,
                       output hit, output rdata);
endinterface : pm_cap_if

// >>> src/pm_cap_pkg.sv
// Purpose: Shared constants for the power-management capabilities word.
// Assumes: 16-bit word in the function's configuration space.
// Notes:   Field positions, fixed codes and reset values live here.

package pm_cap_pkg;

    // ------------------------------------------------------------------
    // Placement in configuration space
    // ------------------------------------------------------------------
    localparam logic [7:0]  CAPS_OFFSET      = 8'h46;
    localparam logic [7:0]  CAPS_DWORD       = 8'h44;
    localparam logic [7:0]  MISC_OFFSET      = 8'hF0;

    // ------------------------------------------------------------------
    // Field positions inside the capabilities word
    // ------------------------------------------------------------------
    localparam int          COLD_WAKE_BIT    = 15;
    localparam int          WAKE_MASK_HI     = 14;
    localparam int          WAKE_MASK_LO     = 11;
    localparam int          DEEP_DOZE_BIT    = 10;
    localparam int          LIGHT_DOZE_BIT   = 9;
    localparam int          STANDBY_HI       = 8;
    localparam int          STANDBY_LO       = 6;
    localparam int          DEV_INIT_BIT     = 5;
    localparam int          RSVD_BIT         = 4;
    localparam int          WAKE_CLOCK_BIT   = 3;
    localparam int          SPEC_LEVEL_HI    = 2;
    localparam int          SPEC_LEVEL_LO    = 0;

    // Cold-wake bit position inside the miscellaneous register
    localparam int          MISC_COLD_BIT    = 15;

    // ------------------------------------------------------------------
    // Fixed field values
    // ------------------------------------------------------------------
    localparam logic [3:0]  WAKE_STATE_MASK  = 4'hF;
    localparam logic        DEEP_DOZE_VAL    = 1'b1;
    localparam logic        LIGHT_DOZE_VAL   = 1'b1;
    localparam logic [2:0]  STANDBY_SELF     = 3'h0;
    localparam logic [2:0]  STANDBY_55MA     = 3'h1;
    localparam logic        DEV_INIT_VAL     = 1'b0;
    localparam logic        RSVD_VAL         = 1'b0;
    localparam logic        WAKE_CLOCK_VAL   = 1'b0;
    localparam logic [2:0]  PM_SPEC_LEVEL    = 3'h2;

    // ------------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------------
    localparam logic [15:0] CAPS_RESET       = 16'h7E02;
    localparam logic [15:0] MISC_RESET       = 16'h0000;
    localparam logic [31:0] RDATA_RESET      = 32'h0000_0000;

endpackage : pm_cap_pkg

// >>> src/pm_caps_reg.sv
// Purpose: Read-only power-management capabilities word for config space.
// Assumes: Config requests and the storage loader share this clock.
// Notes:   One-cycle answer; writes are acknowledged but change nothing.

`timescale 1ns/1ps

module pm_caps_reg (
    // Clock, reset and enable
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        ce,
    // Configuration access port
    input  wire logic        cfg_rd,
    input  wire logic        cfg_wr,
    input  wire logic [7:0]  cfg_addr,
    input  wire logic [3:0]  cfg_be,
    input  wire logic [31:0] cfg_wdata,
    output logic             cfg_ack,
    output logic             cfg_hit,
    output logic [31:0]      cfg_rdata,
    // Nonvolatile storage loader
    input  wire logic        store_valid,
    input  wire logic [15:0] store_data,
    input  wire logic        store_done,
    // Decoded capability state
    output logic             wake_from_cold_capable,
    output logic [2:0]       standby_supply,
    output logic [15:0]      caps_word,
    output logic             misc_loaded
);

    // ------------------------------------------------------------------
    // Shared carrier and leaf blocks
    // ------------------------------------------------------------------
    pm_cap_if cap ();

    misc_shadow u_shadow (
        .clock       (clock),
        .rst_n       (rst_n),
        .ce          (ce),
        .store_valid (store_valid),
        .store_data  (store_data),
        .store_done  (store_done),
        .cap         (cap.shadow)
    );

    cfg_reply_mux u_reply (
        .cap (cap.reply)
    );

    // ------------------------------------------------------------------
    // Field assembly
    // ------------------------------------------------------------------
    logic        cold_wake;
    logic [3:0]  wake_state_mask;
    logic        deep_doze_supported;
    logic        light_doze_supported;
    logic [2:0]  standby_code;
    logic        dev_init_needed;
    logic        rsvd_field;
    logic        wake_clock_needed;
    logic [2:0]  pm_spec_level;
    logic [15:0] caps_next;

    // Cold-wake capability follows the miscellaneous word
    assign cold_wake = cap.cold_wake;

    // Fixed capability fields, wired so no write path reaches them
    assign wake_state_mask      = pm_cap_pkg::WAKE_STATE_MASK;
    assign deep_doze_supported  = pm_cap_pkg::DEEP_DOZE_VAL;
    assign light_doze_supported = pm_cap_pkg::LIGHT_DOZE_VAL;
    assign dev_init_needed      = pm_cap_pkg::DEV_INIT_VAL;
    assign rsvd_field           = pm_cap_pkg::RSVD_VAL;
    assign wake_clock_needed    = pm_cap_pkg::WAKE_CLOCK_VAL;
    assign pm_spec_level        = pm_cap_pkg::PM_SPEC_LEVEL;

    // Standby current: self-powered unless cold wake is advertised
    assign standby_code = cold_wake ? pm_cap_pkg::STANDBY_55MA
                                    : pm_cap_pkg::STANDBY_SELF;

    // Pack the fields into their documented positions
    always_comb begin
        caps_next = 16'h0000;
        caps_next[pm_cap_pkg::COLD_WAKE_BIT] = cold_wake;
        caps_next[pm_cap_pkg::WAKE_MASK_HI:pm_cap_pkg::WAKE_MASK_LO]
            = wake_state_mask;
        caps_next[pm_cap_pkg::DEEP_DOZE_BIT]  = deep_doze_supported;
        caps_next[pm_cap_pkg::LIGHT_DOZE_BIT] = light_doze_supported;
        caps_next[pm_cap_pkg::STANDBY_HI:pm_cap_pkg::STANDBY_LO]
            = standby_code;
        caps_next[pm_cap_pkg::DEV_INIT_BIT]   = dev_init_needed;
        caps_next[pm_cap_pkg::RSVD_BIT]       = rsvd_field;
        caps_next[pm_cap_pkg::WAKE_CLOCK_BIT] = wake_clock_needed;
        caps_next[pm_cap_pkg::SPEC_LEVEL_HI:pm_cap_pkg::SPEC_LEVEL_LO]
            = pm_spec_level;
    end

    // ------------------------------------------------------------------
    // Held capabilities word
    // ------------------------------------------------------------------
    logic [15:0] caps_reg;

    // Refreshed every enabled cycle; no write input reaches it, so a
    // config write can never alter a bit, only a storage reload can
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            caps_reg <= pm_cap_pkg::CAPS_RESET;
        end else if (ce) begin
            caps_reg <= caps_next;
        end
    end

    // Reply mux reads the held word, so a read sees one consistent value
    assign cap.caps_word = caps_reg;
    assign cap.addr      = cfg_addr;
    assign cap.be        = cfg_be;

    // ------------------------------------------------------------------
    // Configuration answer
    // ------------------------------------------------------------------
    logic        req_take;
    logic        ack_reg;
    logic        hit_reg;
    logic [31:0] rdata_reg;

    // A read and a write in one cycle count as one request
    assign req_take = ce && (cfg_rd || cfg_wr);

    // Acknowledge strobe, one cycle after the request edge
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ack_reg <= 1'b0;
        end else if (ce) begin
            ack_reg <= req_take;
        end
    end

    // Claim indication follows every request, read or write
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            hit_reg <= 1'b0;
        end else if (ce) begin
            hit_reg <= req_take && cap.hit;
        end
    end

    // Read data only for claimed reads; writes return zero and the
    // write data is dropped, keeping the word strictly read-only
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rdata_reg <= pm_cap_pkg::RDATA_RESET;
        end else if (ce) begin
            if (req_take && cfg_rd && cap.hit) begin
                rdata_reg <= cap.rdata;
            end else begin
                rdata_reg <= pm_cap_pkg::RDATA_RESET;
            end
        end
    end

    assign cfg_ack   = ack_reg;
    assign cfg_hit   = hit_reg;
    assign cfg_rdata = rdata_reg;

    // ------------------------------------------------------------------
    // Decoded state outputs
    // ------------------------------------------------------------------
    logic       cold_out_reg;
    logic [2:0] standby_out_reg;
    logic       loaded_out_reg;

    // Taken from the held word one enabled cycle later, so pins change in step with config read data
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cold_out_reg    <= pm_cap_pkg::CAPS_RESET[
                pm_cap_pkg::COLD_WAKE_BIT];
            standby_out_reg <= pm_cap_pkg::CAPS_RESET[
                pm_cap_pkg::STANDBY_HI:pm_cap_pkg::STANDBY_LO];
        end else if (ce) begin
            cold_out_reg    <= caps_reg[pm_cap_pkg::COLD_WAKE_BIT];
            standby_out_reg <= caps_reg[
                pm_cap_pkg::STANDBY_HI:pm_cap_pkg::STANDBY_LO];
        end
    end

    // Load-complete status for the surrounding function
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            loaded_out_reg <= 1'b0;
        end else if (ce) begin
            loaded_out_reg <= cap.misc_loaded;
        end
    end

    assign wake_from_cold_capable = cold_out_reg;
    assign standby_supply         = standby_out_reg;
    assign caps_word              = caps_reg;
    assign misc_loaded            = loaded_out_reg;

endmodule : pm_caps_reg
